// ==== common/csfl_regs.vh ====
// Register offsets, field positions and reset values of the status flag block.
`ifndef CSFL_REGS_VH
`define CSFL_REGS_VH

`define CSFL_FLAGS_OFS      12'h000
`define CSFL_CMD_OFS        12'h004
`define CSFL_OPND_OFS       12'h008
`define CSFL_RESULT_OFS     12'h00c

`define CSFL_BIT_CARRY      0
`define CSFL_BIT_HALF       1
`define CSFL_BIT_ZERO       2
`define CSFL_BIT_OVF        3
`define CSFL_BIT_HALT       4
`define CSFL_BIT_DOG        5
`define CSFL_BIT_CHAIN      6
`define CSFL_BIT_SIGNED     7

`define CSFL_FLAGS_RST      8'h00
`define CSFL_WR_MASK        8'h0f

`define CSFL_OP_NONE        4'h0
`define CSFL_OP_ADD         4'h1
`define CSFL_OP_ADC         4'h2
`define CSFL_OP_SUB         4'h3
`define CSFL_OP_SUB_BRW     4'h4
`define CSFL_OP_LOGIC       4'h5
`define CSFL_OP_RLC         4'h6
`define CSFL_OP_RRC         4'h7
`define CSFL_OP_DOG_CLR     4'h8
`define CSFL_OP_HALT        4'h9
`define CSFL_OP_FLAG_WR     4'ha
`define CSFL_OP_CALL        4'hb

`endif

// ==== hw/csfl_alu_flags.v ====
// Combinational flag computation for one instruction result.
`timescale 1ns/1ps
module csfl_alu_flags
(
    // Operation
    input  wire [3:0] op,
    input  wire [7:0] opnd_a,
    input  wire [7:0] opnd_b,
    input  wire       carry_in,
    // Results
    output reg  [7:0] result,
    output reg        carry_out,
    output reg        half_out,
    output reg        ovf_out,
    output reg        arith
);
`include "csfl_regs.vh"

    reg [8:0] sum;
    reg [4:0] low;
    reg [7:0] bin;
    reg       cin;
    reg       c7;

    always @*
    begin
        bin       = opnd_b;
        cin       = 1'b0;
        sum       = 9'h000;
        low       = 5'h00;
        c7        = 1'b0;
        result    = opnd_a;
        carry_out = carry_in;
        half_out  = 1'b0;
        ovf_out   = 1'b0;
        arith     = 1'b0;
        case (op)
            `CSFL_OP_ADD, `CSFL_OP_ADC, `CSFL_OP_SUB, `CSFL_OP_SUB_BRW:
            begin
                // Subtraction adds the inverse, so carry out means no borrow.
                bin   = (op == `CSFL_OP_SUB || op == `CSFL_OP_SUB_BRW) ? ~opnd_b : opnd_b;
                cin   = (op == `CSFL_OP_SUB) ? 1'b1 : (op == `CSFL_OP_ADD) ? 1'b0 : carry_in;
                sum   = {1'b0, opnd_a} + {1'b0, bin} + {8'h00, cin};
                low   = {1'b0, opnd_a[3:0]} + {1'b0, bin[3:0]} + {4'h0, cin};
                c7    = opnd_a[7] ^ bin[7] ^ sum[7];
                result    = sum[7:0];
                carry_out = sum[8];
                half_out  = low[4];
                ovf_out   = c7 ^ sum[8];
                arith     = 1'b1;
            end
            `CSFL_OP_LOGIC:
            begin
                result = opnd_a & opnd_b;
                arith  = 1'b1;
            end
            `CSFL_OP_RLC:
            begin
                result    = {opnd_a[6:0], carry_in};
                carry_out = opnd_a[7];
            end
            `CSFL_OP_RRC:
            begin
                result    = {carry_in, opnd_a[7:1]};
                carry_out = opnd_a[0];
            end
            default:
            begin
                result = opnd_a;
            end
        endcase
    end
endmodule

// ==== hw/csfl_top.v ====
// Status flag register of the core with an AHB-Lite register slave.
//
// Functional notes
// - No automatic flag save on interrupt or call.
// - Signed compare equals overflow XOR result MSB.
// - Plain subtract copies zero into chained zero.
// - Borrow subtract ANDs chained zero with zero.
// - Other instructions leave chained zero alone.
// - Dog flag cleared by reset, clear, halt.
// - Halt flag cleared by reset, clear; halt sets.
// - Overflow is carry into MSB XOR out.
// - Zero flag follows arithmetic or logic result.
// - Half carry from low nibble, inverted borrow.
// - Carry on add carry or subtract no-borrow.
// - Rotate through carry updates carry flag.
// - Software writes never touch dog, halt flags.
`timescale 1ns/1ps
module csfl_top
(
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // Datapath instruction port
    input  wire        instr_valid,
    input  wire [3:0]  instr_op,
    input  wire [7:0]  instr_a,
    input  wire [7:0]  instr_b,
    // Watchdog event from the timer domain pin
    input  wire        dog_expiry,
    // Flag and result outputs
    output reg  [7:0]  cpu_flags,
    output reg  [7:0]  instr_result
);
`include "csfl_regs.vh"

////////////////////////////////////////////////////////////////////////////////

    reg        dog_s1_q;
    reg        dog_s2_q;
    reg        dog_s3_q;
    reg        ph_wr_q;
    reg [11:0] ph_addr_q;
    reg [7:0]  opnd_q;
    reg [7:0]  flags_d;
    reg [3:0]  op_d;
    reg [7:0]  a_d;
    reg [7:0]  b_d;
    reg        go_d;
    reg        sw_wr;
    reg [7:0]  sw_val;
    wire [7:0] res;
    wire       c_out;
    wire       h_out;
    wire       v_out;
    wire       arith;
    wire       dog_evt;
    wire       zero;

    // The watchdog line comes from another clock, so it is synchronised first.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dog_s1_q <= 1'b0;
            dog_s2_q <= 1'b0;
            dog_s3_q <= 1'b0;
        end
        else
        begin
            dog_s1_q <= dog_expiry;
            dog_s2_q <= dog_s1_q;
            dog_s3_q <= dog_s2_q;
        end
    end

    assign dog_evt = dog_s2_q & ~dog_s3_q;

////////////////////////////////////////////////////////////////////////////////

    wire addr_phase = hsel & hready & htrans[1];

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_wr_q   <= 1'b0;
            ph_addr_q <= 12'h000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hready)
            begin
                ph_wr_q   <= addr_phase & hwrite;
                ph_addr_q <= haddr[11:0];
            end
        end
    end

    // Read data is prepared in the address phase so that it stands registered.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (addr_phase && !hwrite)
        begin
            case (haddr[11:0])
                `CSFL_FLAGS_OFS:  hrdata <= {24'h000000, flags_d};
                `CSFL_OPND_OFS:   hrdata <= {24'h000000, opnd_q};
                `CSFL_RESULT_OFS: hrdata <= {24'h000000, instr_result};
                default:          hrdata <= 32'h00000000;
            endcase
        end
    end

////////////////////////////////////////////////////////////////////////////////

    // A bus write to the command register issues one instruction; the datapath port has priority.
    always @*
    begin
        sw_wr  = ph_wr_q && (ph_addr_q == `CSFL_FLAGS_OFS);
        sw_val = hwdata[7:0];
        go_d   = instr_valid | (ph_wr_q && (ph_addr_q == `CSFL_CMD_OFS));
        op_d   = instr_valid ? instr_op : hwdata[3:0];
        a_d    = instr_valid ? instr_a : opnd_q;
        b_d    = instr_valid ? instr_b : hwdata[15:8];
        // Only an issued instruction may write through its operand; a bus write keeps its own data.
        if (go_d && op_d == `CSFL_OP_FLAG_WR && !sw_wr)
        begin
            sw_wr  = 1'b1;
            sw_val = a_d;
        end
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            opnd_q <= 8'h00;
        else if (ph_wr_q && ph_addr_q == `CSFL_OPND_OFS)
            opnd_q <= hwdata[7:0];
    end

    csfl_alu_flags u_alu
    (
        .op        (go_d ? op_d : `CSFL_OP_NONE),
        .opnd_a    (a_d),
        .opnd_b    (b_d),
        .carry_in  (cpu_flags[`CSFL_BIT_CARRY]),
        .result    (res),
        .carry_out (c_out),
        .half_out  (h_out),
        .ovf_out   (v_out),
        .arith     (arith)
    );

    assign zero = (res == 8'h00);

////////////////////////////////////////////////////////////////////////////////

    // Calls and interrupts only change the program counter; no flag copy is made here.
    always @*
    begin
        flags_d = cpu_flags;
        if (go_d && arith)
        begin
            flags_d[`CSFL_BIT_ZERO] = zero;
            flags_d[`CSFL_BIT_OVF]  = v_out;
            flags_d[`CSFL_BIT_SIGNED] = v_out ^ res[7];
            if (op_d != `CSFL_OP_LOGIC)
            begin
                flags_d[`CSFL_BIT_CARRY] = c_out;
                flags_d[`CSFL_BIT_HALF]  = h_out;
            end
            if (op_d == `CSFL_OP_SUB)
                flags_d[`CSFL_BIT_CHAIN] = zero;
            else if (op_d == `CSFL_OP_SUB_BRW)
                flags_d[`CSFL_BIT_CHAIN] = cpu_flags[`CSFL_BIT_CHAIN] & zero;
            // Other opcodes keep chained zero as it was.
        end
        if (go_d && (op_d == `CSFL_OP_RLC || op_d == `CSFL_OP_RRC))
            flags_d[`CSFL_BIT_CARRY] = c_out;
        if (go_d && op_d == `CSFL_OP_DOG_CLR)
        begin
            flags_d[`CSFL_BIT_DOG]  = 1'b0;
            flags_d[`CSFL_BIT_HALT] = 1'b0;
        end
        if (go_d && op_d == `CSFL_OP_HALT)
        begin
            flags_d[`CSFL_BIT_DOG]  = 1'b0;
            flags_d[`CSFL_BIT_HALT] = 1'b1;
        end
        // A time-out arriving with a clear still leaves the flag set.
        if (dog_evt)
            flags_d[`CSFL_BIT_DOG] = 1'b1;
        // Only the low four bits take written data.
        if (sw_wr)
            flags_d = (flags_d & ~`CSFL_WR_MASK) | (sw_val & `CSFL_WR_MASK);
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cpu_flags    <= `CSFL_FLAGS_RST;
            instr_result <= 8'h00;
        end
        else
        begin
            cpu_flags <= flags_d;
            if (go_d)
                instr_result <= res;
        end
    end
endmodule

// ==== tb/csfl_top_props.sv ====
// Port checker for the status flag block.
`timescale 1ns/1ps
`include "csfl_regs.vh"
module csfl_top_chk
(
    // Clock, reset and bus
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    // Instruction port and flags
    input wire        instr_valid,
    input wire [3:0]  instr_op,
    input wire [7:0]  instr_a,
    input wire [7:0]  instr_b,
    input wire [7:0]  cpu_flags,
    input wire [7:0]  instr_result
);
    ////////////////////////////////////////////////////////////////////////////////
    logic       fw_q;
    logic [8:0] sum9;
    logic       iv;
    assign sum9 = {1'b0, instr_a} + {1'b0, instr_b};
    assign iv = instr_valid && !fw_q;
    // A flag write in its data phase overrides the low nibble, so it masks the arithmetic checks.
    always @(posedge hclk or negedge hresetn)
        if (!hresetn)
            fw_q <= 1'b0;
        else
            fw_q <= hsel && hready && htrans[1] && hwrite && haddr[11:0] == `CSFL_FLAGS_OFS;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////////////////////////////////////////////
    a_halt_marks:
        assert property (instr_valid && instr_op == `CSFL_OP_HALT |=> cpu_flags[5:4] == 2'b01) else $error("halt");
    a_clear_both:
        assert property (instr_valid && instr_op == `CSFL_OP_DOG_CLR |=> cpu_flags[5:4] == 2'b00) else $error("clr");
    a_sub_copies:
        assert property (iv && instr_op == `CSFL_OP_SUB |=> cpu_flags[6] == cpu_flags[2]) else $error("sub chain");
    a_borrow_chains:
        assert property (iv && instr_op == `CSFL_OP_SUB_BRW |=> cpu_flags[6] == ($past(cpu_flags[6]) & cpu_flags[2]))
            else $error("borrow chain");
    a_chain_held:
        assert property (instr_valid && instr_op != `CSFL_OP_SUB && instr_op != `CSFL_OP_SUB_BRW
            |=> $stable(cpu_flags[6])) else $error("chain zero moved");
    a_signed_xor:
        assert property (iv && instr_op inside {[`CSFL_OP_ADD:`CSFL_OP_LOGIC]}
            |=> cpu_flags[7] == (cpu_flags[3] ^ instr_result[7])) else $error("signed compare");
    a_add_sum:
        assert property (iv && instr_op == `CSFL_OP_ADD |=> instr_result == $past(sum9[7:0])
            && cpu_flags[0] == $past(sum9[8]) && cpu_flags[2] == (instr_result == 8'h00)) else $error("add");
    a_add_ovf:
        assert property (iv && instr_op == `CSFL_OP_ADD |=> cpu_flags[3] == ($past(instr_a[7]) == $past(instr_b[7])
            && instr_result[7] != $past(instr_a[7]))) else $error("ovf");
    a_rlc_carry:
        assert property (iv && instr_op == `CSFL_OP_RLC |=> cpu_flags[0] == $past(instr_a[7])
            && instr_result == {$past(instr_a[6:0]), $past(cpu_flags[0])}) else $error("rlc");
    a_wr_keeps:
        assert property (fw_q && !instr_valid |=> $stable(cpu_flags[5:4])) else $error("top bits written");
    a_sw_wins:
        assert property (fw_q |=> cpu_flags[3:0] == $past(hwdata[3:0])) else $error("flag write");
endmodule
bind csfl_top csfl_top_chk i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .instr_valid, .instr_op, .instr_a, .instr_b, .cpu_flags, .instr_result);

// ==== tb/csfl_dpath_model.sv ====
// Instruction datapath model issuing one instruction per call.
`timescale 1ns/1ps
module csfl_dpath_model
(
    // Clock
    input  wire        hclk,
    // Instruction port
    output logic       instr_valid,
    output logic [3:0] instr_op,
    output logic [7:0] instr_a,
    output logic [7:0] instr_b
);
    initial
    begin
        instr_valid = 1'b0;
        instr_op = 4'h0;
        instr_a = 8'h00;
        instr_b = 8'h00;
    end
    // Operands are inverted once idle so a stale operand is never mistaken for a fresh one.
    task automatic issue(input logic [3:0] op, input logic [7:0] a, input logic [7:0] b);
        @(posedge hclk);
        instr_valid <= 1'b1;
        instr_op <= op;
        instr_a <= a;
        instr_b <= b;
        @(posedge hclk);
        instr_valid <= 1'b0;
        instr_a <= ~a;
        instr_b <= ~b;
    endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the status flag block.
`timescale 1ns/1ps
`include "csfl_regs.vh"
`define CHK(n, e, v) begin samples_checked++; if ((v) !== (e)) begin fail_count++; \
    $display("wrong value %s expected %h seen %h", n, e, v); end end
module testbench;
    logic        hclk, hresetn, hsel, hwrite, dog_expiry;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0]  htrans;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, iv;
    wire  [3:0]  op;
    wire  [7:0]  ia, ib, cpu_flags, instr_result;
    int          fail_count, samples_checked;
    csfl_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .instr_valid(iv), .instr_op(op), .instr_a(ia), .instr_b(ib), .dog_expiry(dog_expiry),
        .cpu_flags(cpu_flags), .instr_result(instr_result));
    csfl_dpath_model i_dp (.hclk(hclk), .instr_valid(iv), .instr_op(op), .instr_a(ia), .instr_b(ib));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        `CHK("response", 1'b0, hresp)
    endtask
    task automatic rdc(input logic [11:0] a, input logic [7:0] e, input string n);
        bus(1'b0, a, 32'h0);
        `CHK(n, {24'h0, e}, rd)
    endtask
    task automatic fc(input logic [7:0] m, input logic [7:0] e, input string n);
        #1;
        `CHK(n, e & m, cpu_flags & m)
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    // Whole run is under a hundred cycles; this limit leaves ample margin.
    initial
    begin
        #100000;
        fail_count++;
        close_out();
    end
    initial
    begin
        {hresetn, hsel, hwrite, dog_expiry, htrans, haddr, hwdata} = '0;
        fail_count = 0;
        samples_checked = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(`CSFL_FLAGS_OFS, 8'h00, "reset flags");
        rdc(12'h010, 8'h00, "unmapped");
        i_dp.issue(`CSFL_OP_ADD, 8'h8f, 8'h71); fc(8'hff, 8'h07, "add wrap");
        i_dp.issue(`CSFL_OP_ADD, 8'h40, 8'h40); fc(8'hff, 8'h08, "add ovf");
        i_dp.issue(`CSFL_OP_SUB, 8'h00, 8'h01); fc(8'hff, 8'h80, "sub borrow");
        i_dp.issue(`CSFL_OP_SUB, 8'h05, 8'h05); fc(8'hff, 8'h47, "sub equal");
        i_dp.issue(`CSFL_OP_SUB_BRW, 8'h05, 8'h05); fc(8'hff, 8'h47, "borrow chain");
        i_dp.issue(`CSFL_OP_SUB_BRW, 8'h03, 8'h01); fc(8'hff, 8'h03, "borrow break");
        i_dp.issue(`CSFL_OP_LOGIC, 8'hf0, 8'h0f); fc(8'hff, 8'h07, "logic");
        i_dp.issue(`CSFL_OP_CALL, 8'h00, 8'h00); fc(8'hff, 8'h07, "call");
        i_dp.issue(`CSFL_OP_RLC, 8'h80, 8'h00); fc(8'h41, 8'h01, "rlc");
        `CHK("rlc result", 8'h01, instr_result)
        i_dp.issue(`CSFL_OP_RRC, 8'h02, 8'h00); fc(8'h41, 8'h00, "rrc");
        `CHK("rrc result", 8'h81, instr_result)
        i_dp.issue(`CSFL_OP_HALT, 8'h00, 8'h00); fc(8'h30, 8'h10, "halt");
        bus(1'b1, `CSFL_FLAGS_OFS, 32'hff); fc(8'h7f, 8'h1f, "sw write");
        dog_expiry <= 1'b1;
        for (int k = 0; k < 8 && cpu_flags[5] !== 1'b1; k++) @(posedge hclk);
        fc(8'h30, 8'h30, "dog expiry");
        dog_expiry <= 1'b0;
        i_dp.issue(`CSFL_OP_HALT, 8'h00, 8'h00); fc(8'h30, 8'h10, "halt clears dog");
        i_dp.issue(`CSFL_OP_DOG_CLR, 8'h00, 8'h00); fc(8'h30, 8'h00, "dog clear");
        i_dp.issue(`CSFL_OP_ADC, 8'h7f, 8'h00); fc(8'hff, 8'h0a, "add carry");
        i_dp.issue(`CSFL_OP_FLAG_WR, 8'hf5, 8'h00); fc(8'hff, 8'h05, "direct write");
        bus(1'b1, `CSFL_FLAGS_OFS, 32'h0a); fc(8'h0f, 8'h0a, "bus write");
        rdc(`CSFL_FLAGS_OFS, 8'h0a, "flag readback");
        fork
            bus(1'b1, `CSFL_FLAGS_OFS, 32'h0);
            begin
                @(posedge hclk);
                i_dp.issue(`CSFL_OP_ADD, 8'hff, 8'h01);
            end
        join
        fc(8'h0f, 8'h00, "write beats add");
        bus(1'b1, `CSFL_OPND_OFS, 32'h10);
        bus(1'b1, `CSFL_CMD_OFS, 32'h2001);
        rdc(`CSFL_RESULT_OFS, 8'h30, "command result");
        bus(1'b1, `CSFL_RESULT_OFS, 32'h55);
        rdc(`CSFL_RESULT_OFS, 8'h30, "result read only");
        rdc(`CSFL_OPND_OFS, 8'h10, "operand");
        i_dp.issue(`CSFL_OP_HALT, 8'h00, 8'h00); fc(8'h30, 8'h10, "halt again");
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(`CSFL_FLAGS_OFS, 8'h00, "flags after reset");
        close_out();
    end
endmodule
